// ==== rtl/crjm_iir1.sv ====
// first-order low-pass or high-pass section stepped once per sample
`timescale 1ns/1ps
`include "crjm_regs.svh"
module crjm_iir1 (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               step,
    input  wire logic               hp_mode,
    input  wire logic [4:0]         shift,
    input  wire logic signed [31:0] x,
    output logic signed [31:0]      y
);
    logic signed [31:0] acc_ff;
    logic signed [31:0] y_ff;
    wire  signed [31:0] diff    = x - acc_ff;
    wire  signed [31:0] nxt_acc = acc_ff + (diff >>> shift);
    wire  signed [31:0] nxt_y   = hp_mode ? diff : nxt_acc;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_ff <= `CRJM_ZERO;
            y_ff   <= `CRJM_ZERO;
        end else if (step) begin
            acc_ff <= nxt_acc;
            y_ff   <= nxt_y;
        end
    end
    assign y = y_ff;
endmodule

// ==== rtl/crjm_meter.sv ====
// clock reference jitter meter: accuracy, jitter, drift and offset per sample
`timescale 1ns/1ps
`include "crjm_regs.svh"
// Summary of operation
// - count stream bytes between this and the previous clock sample
// - accuracy derivative is sample delta minus byte count over byte rate
// - accuracy is updated only for constant bitrate streams
// - all filters except the interval average follow the four selectable bandwidth options
// - jitter path is third-order high-pass overall
// - drift-rate path has a first-order low-pass roll-off
// - drift-rate taken from loop error, then first-order low-pass
// - frequency offset taken after accumulator, then first-order low-pass
// - jitter taken from loop error, then extra first-order high-pass
// - tracking loop is type II: accumulator plus oscillator
// - average sample interval is low-pass filtered near 10 mHz
// - bandwidth filter coefficients scale with the averaged sample rate; the interval average shift is fixed
// - converter code is the oscillator control scaled by two to minus eighteen
// - only two consecutive samples are needed per measurement
// - flag drift rate beyond its limit; phase may exceed 500 ns there
// - sample interval error derived from byte count over byte rate
// - individual accuracy recovered assuming zero mean inaccuracy
module crjm_meter #(
    parameter int GAP_MAX_CYC = `CRJM_GAP_MAX_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   meas_start,
    input  wire logic                   cbr_mode,
    input  wire crjm_pkg::crjm_bw_type  bw_select,
    input  wire logic [31:0]            nominal_byte_period_q16,
    input  wire logic                   ts_byte_valid,
    input  wire logic                   pcr_valid,
    input  wire logic [41:0]            pcr_value,
    output crjm_pkg::crjm_result_type   result,
    output logic                        result_valid,
    output logic                        drift_limit_exceeded,
    output logic                        sample_gap_error
);
    import crjm_pkg::*;

    localparam logic [23:0] GAP_LIMIT = 24'(GAP_MAX_CYC);
    localparam int          NFILT     = 5;

    crjm_state_type     st_ff;
    crjm_state_type     nxt_st;
    logic [41:0]        last_pcr_ff;
    logic [23:0]        byte_cnt_ff;
    logic [23:0]        ival_ff;
    logic [23:0]        k_ff;
    logic [23:0]        ival_lat_ff;
    logic signed [31:0] dpcr_ff;
    logic               st1_ff;
    logic               st2_ff;
    logic               st3_ff;
    logic               cbr2_ff;
    logic signed [31:0] ac_sum_ff;
    logic signed [31:0] phase_ff;
    logic signed [31:0] freq_ff;
    logic signed [31:0] sie_ff;
    crjm_result_type    result_ff;
    logic               valid_ff;
    logic               drift_flag_ff;
    logic               gap_ff;
    logic signed [31:0] fx [NFILT];
    logic signed [31:0] fy [NFILT];
    logic               fstep [NFILT];
    logic [4:0]         fshift [NFILT];

    // bandwidth option base shift, corrected by how far the measured
    // interval sits from the 40 ms reference; keeps bandwidth in hertz fixed
    function automatic logic [4:0] coef_shift(input crjm_bw_type bw, input logic [23:0] avg);
        logic [4:0] base;
        logic [4:0] msb;
        logic [6:0] s;
        base = `CRJM_BW1_SHIFT;
        msb  = 5'd0;
        for (int i = 0; i < 24; i++) begin
            if (avg[i]) msb = 5'(i);
        end
        case (bw)
            CRJM_BW_OPT1: base = `CRJM_BW1_SHIFT;
            CRJM_BW_OPT2: base = `CRJM_BW2_SHIFT;
            CRJM_BW_OPT3: base = `CRJM_BW3_SHIFT;
            default:      base = `CRJM_BW4_SHIFT;
        endcase
        s = 7'(base) + 7'(`CRJM_REF_MSB) - 7'(msb);
        if (s < 7'(`CRJM_SHIFT_MIN)) coef_shift = `CRJM_SHIFT_MIN;
        else if (s > 7'(`CRJM_SHIFT_MAX)) coef_shift = `CRJM_SHIFT_MAX;
        else coef_shift = 5'(s);
    endfunction

    wire        pcr_take   = pcr_valid && (st_ff != CRJM_IDLE);
    wire        run_take   = pcr_take && (st_ff == CRJM_RUN);
    wire [23:0] byte_next  = byte_cnt_ff + 24'(ts_byte_valid);
    wire [23:0] ival_next  = (ival_ff == GAP_LIMIT) ? ival_ff : ival_ff + 24'h000001;
    wire [41:0] pcr_delta  = pcr_value - last_pcr_ff;
    wire [55:0] exp_prod   = 56'(k_ff) * 56'(nominal_byte_period_q16);
    wire [55:0] arr_prod   = 56'(ival_lat_ff) * 56'(`CRJM_TICK_RATIO_Q16);
    wire signed [31:0] exp_ticks = signed'(exp_prod[47:16]);
    wire signed [31:0] arr_ticks = signed'(arr_prod[47:16]);
    wire signed [31:0] acc_deriv = dpcr_ff - exp_ticks;
    wire signed [31:0] loop_err  = dpcr_ff - arr_ticks - freq_ff;
    wire [23:0] avg_ival   = fy[4][23:0];
    wire [4:0]  bw_shift   = coef_shift(bw_select, avg_ival);
    wire [31:0] drift_abs  = fy[2][31] ? 32'(-fy[2]) : 32'(fy[2]);

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            CRJM_IDLE:  if (meas_start) nxt_st = CRJM_PRIME;
            CRJM_PRIME: if (!meas_start) nxt_st = CRJM_IDLE;
                        else if (pcr_valid) nxt_st = CRJM_RUN;
            CRJM_RUN:   if (!meas_start) nxt_st = CRJM_IDLE;
            default:    nxt_st = CRJM_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff       <= CRJM_IDLE;
            last_pcr_ff <= 42'h0;
            byte_cnt_ff <= 24'h0;
            ival_ff     <= 24'h0;
        end else begin
            st_ff <= nxt_st;
            if (pcr_take) begin
                last_pcr_ff <= pcr_value;
                byte_cnt_ff <= 24'(ts_byte_valid);
                ival_ff     <= 24'h0;
            end else begin
                byte_cnt_ff <= byte_next;
                ival_ff     <= ival_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st1_ff      <= 1'b0;
            k_ff        <= 24'h0;
            ival_lat_ff <= 24'h0;
            dpcr_ff     <= `CRJM_ZERO;
        end else begin
            st1_ff <= run_take;
            if (run_take) begin
                k_ff        <= byte_next;
                ival_lat_ff <= ival_next;
                dpcr_ff     <= signed'(pcr_delta[31:0]);
            end
        end
    end

    // stage two: accuracy integral and phase detector of the tracking loop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st2_ff    <= 1'b0;
            cbr2_ff   <= 1'b0;
            ac_sum_ff <= `CRJM_ZERO;
            phase_ff  <= `CRJM_ZERO;
            sie_ff    <= `CRJM_ZERO;
        end else begin
            st2_ff <= st1_ff;
            if (st1_ff) begin
                // held for the whole sample so stages two and three agree
                cbr2_ff <= cbr_mode;
                if (cbr_mode) ac_sum_ff <= ac_sum_ff + acc_deriv;
                phase_ff <= phase_ff + loop_err;
                sie_ff   <= exp_ticks;
            end
        end
    end

    // accumulator is the adder plus latch; oscillator is the phase integral
    always_ff @(posedge clk) begin
        if (sys_rst) freq_ff <= `CRJM_ZERO;
        else if (st2_ff) freq_ff <= freq_ff + (phase_ff >>> `CRJM_LOOP_KI);
    end

    // 0 accuracy hp, 1 jitter hp, 2 drift lp, 3 offset lp, 4 interval lp
    assign fx[0] = ac_sum_ff;
    assign fx[1] = phase_ff;
    assign fx[2] = phase_ff;
    assign fx[3] = freq_ff;
    assign fx[4] = signed'(32'(ival_lat_ff));
    assign fstep[0] = st2_ff && cbr2_ff;
    assign fstep[1] = st2_ff;
    assign fstep[2] = st2_ff;
    assign fstep[3] = st2_ff;
    assign fstep[4] = st2_ff;
    assign fshift[0] = bw_shift;
    assign fshift[1] = bw_shift;
    assign fshift[2] = bw_shift;
    assign fshift[3] = bw_shift;
    assign fshift[4] = `CRJM_AVG_SHIFT;

    generate
        for (genvar g = 0; g < NFILT; g++) begin : g_filt
            crjm_iir1 u_iir (
                .clk     (clk),
                .sys_rst (sys_rst),
                .step    (fstep[g]),
                .hp_mode ((g < 2) ? 1'b1 : 1'b0),
                .shift   (fshift[g]),
                .x       (fx[g]),
                .y       (fy[g])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st3_ff        <= 1'b0;
            valid_ff      <= 1'b0;
            result_ff     <= '0;
            drift_flag_ff <= 1'b0;
            gap_ff        <= 1'b0;
        end else begin
            st3_ff   <= st2_ff;
            valid_ff <= st3_ff;
            if (st3_ff) begin
                if (cbr2_ff) result_ff.clock_sample_accuracy <= fy[0];
                result_ff.clock_sample_overall_jitter <= fy[1];
                result_ff.clock_sample_drift_rate     <= fy[2];
                result_ff.clock_sample_freq_offset    <= fy[3];
                result_ff.average_sample_rate         <= avg_ival;
                result_ff.sample_interval             <= ival_lat_ff;
                result_ff.sample_interval_error       <= sie_ff;
                // top bits only: the converter sees control times 2^-18
                result_ff.converter_code <= freq_ff[31:32-`CRJM_DAC_BITS];
                drift_flag_ff <= drift_abs > `CRJM_DRIFT_LIMIT;
            end
            // a gap of up to 100 ms is tolerated, a longer one is reported, counting saturates
            if (pcr_take) gap_ff <= 1'b0;
            else if (st_ff == CRJM_RUN && ival_next == GAP_LIMIT) gap_ff <= 1'b1;
        end
    end

    assign result               = result_ff;
    assign result_valid         = valid_ff;
    assign drift_limit_exceeded = drift_flag_ff;
    assign sample_gap_error     = gap_ff;

    sequence seq_run_take;
        run_take;
    endsequence
    sequence seq_prime_take;
        (st_ff == CRJM_PRIME) && pcr_valid && meas_start;
    endsequence

    chk_valid_latency: assert property (@(posedge clk) disable iff (sys_rst)
        seq_run_take |-> !valid_ff[*4] ##1 valid_ff) else $error("result not valid four cycles after sample");
    chk_first_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        seq_prime_take |-> ##1 (st_ff == CRJM_RUN) ##0 !st1_ff) else $error("first sample started a measurement");
    chk_byte_restart: assert property (@(posedge clk) disable iff (sys_rst)
        pcr_take |=> byte_cnt_ff == 24'($past(ts_byte_valid))) else $error("byte count not restarted");
    chk_byte_latched: assert property (@(posedge clk) disable iff (sys_rst)
        run_take |=> k_ff == $past(byte_cnt_ff) + 24'($past(ts_byte_valid))) else $error("byte count not latched");
    chk_acc_cbr_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (st2_ff && !cbr2_ff) |-> ##2 $stable(result_ff.clock_sample_accuracy)) else $error("accuracy moved without cbr");
    chk_gap_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff == CRJM_RUN && ival_next == GAP_LIMIT && !pcr_take) |=> gap_ff) else $error("gap not flagged");
    chk_shift_bounds: assert property (@(posedge clk) disable iff (sys_rst)
        bw_shift >= `CRJM_SHIFT_MIN && bw_shift <= `CRJM_SHIFT_MAX) else $error("coefficient shift out of range");
    chk_accum_update: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(st2_ff) |-> $stable(freq_ff)) else $error("accumulator changed between samples");
    chk_dac_scale: assert property (@(posedge clk) disable iff (sys_rst)
        st3_ff |=> result_ff.converter_code == $past(freq_ff[31:18])) else $error("converter code scaling wrong");
    chk_idle_drain: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff == CRJM_IDLE)[*5] |-> !valid_ff) else $error("output while idle");

    sequence seq_cbr_step;
        st1_ff && cbr_mode;
    endsequence
    sequence seq_plain_step;
        st1_ff && !cbr_mode;
    endsequence

    // each stage must latch, step or pass on exactly what it was handed
    chk_sample_latch: assert property (@(posedge clk) disable iff (sys_rst)
        pcr_take |=> last_pcr_ff == $past(pcr_value)) else $error("sample value not latched");
    chk_idle_ignore: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff == CRJM_IDLE) |=> $stable(last_pcr_ff)) else $error("sample taken while idle");
    chk_delta_form: assert property (@(posedge clk) disable iff (sys_rst)
        run_take |=> dpcr_ff == signed'(32'($past(pcr_value) - $past(last_pcr_ff)))) else $error("delta wrong");
    chk_acc_step: assert property (@(posedge clk) disable iff (sys_rst)
        seq_cbr_step |=> ac_sum_ff == $past(ac_sum_ff) + $past(acc_deriv)) else $error("accuracy sum not stepped");
    chk_acc_frozen: assert property (@(posedge clk) disable iff (sys_rst)
        seq_plain_step |=> $stable(ac_sum_ff)) else $error("accuracy sum moved without cbr");
    chk_cbr_latched: assert property (@(posedge clk) disable iff (sys_rst)
        seq_cbr_step |=> cbr2_ff) else $error("cbr mode not latched");
    chk_phase_step: assert property (@(posedge clk) disable iff (sys_rst)
        st1_ff |=> phase_ff == $past(phase_ff) + $past(loop_err)) else $error("phase detector not stepped");
    chk_freq_step: assert property (@(posedge clk) disable iff (sys_rst)
        st2_ff |=> freq_ff == $past(freq_ff) + ($past(phase_ff) >>> `CRJM_LOOP_KI)) else $error("accumulator not stepped");
    chk_sie_path: assert property (@(posedge clk) disable iff (sys_rst)
        st3_ff |=> result_ff.sample_interval_error == $past(sie_ff)) else $error("interval error not passed on");
    chk_jitter_path: assert property (@(posedge clk) disable iff (sys_rst)
        st3_ff |=> result_ff.clock_sample_overall_jitter == $past(fy[1])) else $error("jitter not from high-pass");
    chk_drift_path: assert property (@(posedge clk) disable iff (sys_rst)
        st3_ff |=> result_ff.clock_sample_drift_rate == $past(fy[2])) else $error("drift not from low-pass");
    chk_offset_path: assert property (@(posedge clk) disable iff (sys_rst)
        st3_ff |=> result_ff.clock_sample_freq_offset == $past(fy[3])) else $error("offset not from low-pass");
    chk_avg_path: assert property (@(posedge clk) disable iff (sys_rst)
        st3_ff |=> result_ff.average_sample_rate == $past(avg_ival)) else $error("average interval not passed on");
    chk_drift_flag: assert property (@(posedge clk) disable iff (sys_rst)
        st3_ff |=> drift_flag_ff == ($past(drift_abs) > `CRJM_DRIFT_LIMIT)) else $error("drift flag wrong");
    chk_ival_ceiling: assert property (@(posedge clk) disable iff (sys_rst)
        ival_ff <= GAP_LIMIT) else $error("interval counter past its ceiling");
    chk_gap_cleared: assert property (@(posedge clk) disable iff (sys_rst)
        pcr_take |=> !gap_ff) else $error("gap flag not cleared by sample");
endmodule

// ==== rtl/crjm_pkg.sv ====
// types for the clock reference jitter meter
package crjm_pkg;
    typedef enum logic [1:0] {
        CRJM_IDLE  = 2'b00,
        CRJM_PRIME = 2'b01,
        CRJM_RUN   = 2'b11
    } crjm_state_type;

    typedef enum logic [1:0] {
        CRJM_BW_OPT1 = 2'b00,
        CRJM_BW_OPT2 = 2'b01,
        CRJM_BW_OPT3 = 2'b10,
        CRJM_BW_OPT4 = 2'b11
    } crjm_bw_type;

    typedef struct packed {
        logic signed [31:0] clock_sample_accuracy;
        logic signed [31:0] clock_sample_overall_jitter;
        logic signed [31:0] clock_sample_drift_rate;
        logic signed [31:0] clock_sample_freq_offset;
        logic        [23:0] average_sample_rate;
        logic        [23:0] sample_interval;
        logic signed [31:0] sample_interval_error;
        logic        [13:0] converter_code;
    } crjm_result_type;
endpackage

// ==== rtl/crjm_regs.svh ====
// constants for the clock reference jitter meter
`ifndef CRJM_REGS_SVH
`define CRJM_REGS_SVH
`define CRJM_W             32
`define CRJM_PCR_W         42
`define CRJM_CNT_W         24
`define CRJM_SHIFT_W       5
`define CRJM_NOM_CLK_HZ    27000000
`define CRJM_SYS_CLK_HZ    125000000
`define CRJM_TICK_RATIO_Q16 32'd14156
`define CRJM_GAP_MAX_MS    100
`define CRJM_GAP_MAX_CYC   (`CRJM_GAP_MAX_MS * (`CRJM_SYS_CLK_HZ / 1000))
`define CRJM_AVG_LPF_MHZ   10
`define CRJM_AVG_SHIFT     5'd9
`define CRJM_REF_MSB       5'd22
`define CRJM_SHIFT_MIN     5'd1
`define CRJM_SHIFT_MAX     5'd30
`define CRJM_BW1_SHIFT     5'd10
`define CRJM_BW2_SHIFT     5'd8
`define CRJM_BW3_SHIFT     5'd6
`define CRJM_BW4_SHIFT     5'd4
`define CRJM_LOOP_KI       5'd4
`define CRJM_DAC_BITS      14
`define CRJM_DRIFT_LIMIT_MHZ_S 75
`define CRJM_DRIFT_LIMIT   32'h00000100
`define CRJM_ZERO          32'h00000000
`endif

// ==== sim/crjm_ts_source.sv ====
// transport stream source model: stream byte pulses and clock samples for one program
`timescale 1ns/1ps
module crjm_ts_source #(
    parameter int INTERVAL       = 40,
    parameter int TICKS_PER_BYTE = 27
) (
    input  wire logic        clk,
    input  wire logic        src_en,
    input  wire logic [41:0] src_err,
    output logic             ts_byte_valid,
    output logic             pcr_valid,
    output logic [41:0]      pcr_value
);
    logic [41:0] base_ff = 42'h0;
    int          cnt     = 0;

    // interval scaled down from tens of ms to keep the run short
    always @(negedge clk) begin
        pcr_valid <= 1'b0;
        ts_byte_valid <= 1'b0;
        // sample value is not held once the strobe drops
        pcr_value <= ~pcr_value;
        if (src_en) begin
            if (cnt == INTERVAL - 1) begin
                cnt <= 0;
                pcr_valid <= 1'b1;
                // no byte in the sample cycle so the byte count is exact
                pcr_value <= base_ff + src_err;
            end else begin
                cnt <= cnt + 1;
                ts_byte_valid <= 1'b1;
                base_ff <= base_ff + 42'(TICKS_PER_BYTE);
            end
        end
    end
endmodule

// ==== sim/tb.sv ====
// self-checking testbench for the clock reference jitter meter
`timescale 1ns/1ps
module tb;
    import crjm_pkg::*;
    localparam int GAP = 200;
    localparam int N   = 40;

    logic            clk;
    logic            sys_rst;
    logic            meas_start;
    logic            cbr_mode;
    crjm_bw_type     bw_select;
    logic            ts_byte_valid;
    logic            pcr_valid;
    logic [41:0]     pcr_value;
    crjm_result_type result;
    logic            result_valid;
    logic            drift_limit_exceeded;
    logic            sample_gap_error;
    logic            src_en;
    logic [41:0]     src_err;
    logic [3:0]      take_pipe;
    logic            primed;
    logic [31:0]     acc_held;
    int              fails;
    int              checked;

    crjm_meter #(.GAP_MAX_CYC(GAP)) u_crjm_meter (
        .clk                     (clk),
        .sys_rst                 (sys_rst),
        .meas_start              (meas_start),
        .cbr_mode                (cbr_mode),
        .bw_select               (bw_select),
        .nominal_byte_period_q16 (32'h001b0000),
        .ts_byte_valid           (ts_byte_valid),
        .pcr_valid               (pcr_valid),
        .pcr_value               (pcr_value),
        .result                  (result),
        .result_valid            (result_valid),
        .drift_limit_exceeded    (drift_limit_exceeded),
        .sample_gap_error        (sample_gap_error)
    );

    crjm_ts_source #(.INTERVAL(N), .TICKS_PER_BYTE(27)) u_crjm_ts_source (
        .clk           (clk),
        .src_en        (src_en),
        .src_err       (src_err),
        .ts_byte_valid (ts_byte_valid),
        .pcr_valid     (pcr_valid),
        .pcr_value     (pcr_value)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a result is due four edges after every take except the priming one
    always @(posedge clk) begin
        take_pipe <= sys_rst ? 4'h0 : {take_pipe[2:0], pcr_valid && meas_start && primed};
        primed <= !sys_rst && meas_start && (primed || pcr_valid);
    end

    // compared away from the edge that launches the flag
    always @(negedge clk) begin
        check({31'h0, result_valid}, {31'h0, take_pipe[3]});
    end

    task automatic wait_rv;
        int i;
        i = 0;
        @(negedge clk);
        while (result_valid !== 1'b1 && i < 400) begin
            @(negedge clk);
            i++;
        end
        if (i == 400) begin
            $display("mismatch at %0t: no result in time", $time);
            fails++;
            summarize();
        end
    endtask

    task automatic sc_steady(input crjm_bw_type bw);
        bw_select <= bw;
        meas_start <= 1'b1;
        repeat (3) @(negedge clk);
        src_en <= 1'b1;
        repeat (4) begin
            wait_rv();
            check({8'h0, result.sample_interval}, 32'(N));
            check(result.clock_sample_accuracy, 32'h0);
            check(result.sample_interval_error, 32'((N - 1) * 27));
            check({30'h0, drift_limit_exceeded, sample_gap_error}, 32'h0);
        end
        src_en <= 1'b0;
        repeat (2) @(negedge clk);
        meas_start <= 1'b0;
        repeat (8) @(negedge clk);
    endtask

    task automatic sc_step_and_hold;
        meas_start <= 1'b1;
        repeat (3) @(negedge clk);
        src_en <= 1'b1;
        repeat (2) wait_rv();
        src_err <= 42'h3e8;
        wait_rv();
        check(result.clock_sample_accuracy, 32'h000003e8);
        acc_held = result.clock_sample_accuracy;
        cbr_mode <= 1'b0;
        src_err <= 42'h0;
        wait_rv();
        check(result.clock_sample_accuracy, acc_held);
        cbr_mode <= 1'b1;
    endtask

    task automatic sc_gap;
        src_en <= 1'b0;
        repeat (GAP + 20) @(negedge clk);
        check({31'h0, sample_gap_error}, 32'h1);
        src_en <= 1'b1;
        wait_rv();
        check({31'h0, sample_gap_error}, 32'h0);
        check({8'h0, result.sample_interval}, 32'(GAP));
    endtask

    task automatic sc_idle;
        src_en <= 1'b0;
        repeat (2) @(negedge clk);
        meas_start <= 1'b0;
        repeat (8) @(negedge clk);
        // the monitor expects no result while idle
        src_en <= 1'b1;
        repeat (150) @(negedge clk);
        check({31'h0, result_valid}, 32'h0);
    endtask

    initial begin
        fails = 0;
        checked = 0;
        sys_rst = 1'b1;
        meas_start = 1'b0;
        cbr_mode = 1'b1;
        bw_select = CRJM_BW_OPT1;
        src_en = 1'b0;
        src_err = 42'h0;
        repeat (10) @(negedge clk);
        check(result.clock_sample_accuracy, 32'h0);
        check({29'h0, result_valid, drift_limit_exceeded, sample_gap_error}, 32'h0);
        sys_rst <= 1'b0;
        sc_steady(CRJM_BW_OPT1);
        sc_steady(CRJM_BW_OPT2);
        sc_steady(CRJM_BW_OPT3);
        sc_steady(CRJM_BW_OPT4);
        sc_step_and_hold();
        sc_gap();
        sc_idle();
        summarize();
    end
endmodule
